/* verilog/smd_pkg.sv */
// constants, types and tables for the serial line mode decoder
//
// Overview of operation
// - capture select inputs on rising strobe edge
// - three-bit select code picks the standard
// - code 001: V.11, DTR/test V.10, TM off
// - code 010: V.11, LL RL RI V.10
// - code 011: V.11, DCD and test off
// - code 100: fast group V.35, rest V.28
// - code 110: channels in use at V.28
// - code 111: every driver and receiver off
// - DTE channel assignment, drivers 3,6 unused
// - DCE channel assignment, unused channels off
// - bidir channel 3 receives DTE, drives DCE
// - DCD transceiver drives DCE, receives DTE
// - high-speed group allows V.35 V.11 V.10 V.28
// - handshake no V.35; test/ring V.10/V.28 only
package smd_pkg;

  localparam int CH_N    = 8;
  localparam int BIDIR_N = 3;

  typedef enum logic [2:0] {
    LVL_OFF = 3'h0,
    LVL_V35 = 3'h1,
    LVL_V11 = 3'h2,
    LVL_V10 = 3'h3,
    LVL_V28 = 3'h4
  } smd_lvl_t;

  // interface select codes
  localparam logic [2:0] SEL_V10  = 3'h0;
  localparam logic [2:0] SEL_530A = 3'h1;
  localparam logic [2:0] SEL_530  = 3'h2;
  localparam logic [2:0] SEL_X21  = 3'h3;
  localparam logic [2:0] SEL_V35  = 3'h4;
  localparam logic [2:0] SEL_RSVD = 3'h5;
  localparam logic [2:0] SEL_232  = 3'h6;
  localparam logic [2:0] SEL_PDN  = 3'h7;

  // signal classes a channel may carry
  localparam logic [2:0] CL_DATA = 3'h0;
  localparam logic [2:0] CL_RTS  = 3'h1;
  localparam logic [2:0] CL_DTR  = 3'h2;
  localparam logic [2:0] CL_DCD  = 3'h3;
  localparam logic [2:0] CL_LOW  = 3'h4;
  localparam logic [2:0] CL_OFF  = 3'h5;

  // channel classes, entry 0 is channel 1
  localparam logic [2:0] DTE_DRV [CH_N] = '{CL_DATA, CL_DATA, CL_OFF,
    CL_RTS, CL_DTR, CL_OFF, CL_LOW, CL_LOW};
  localparam logic [2:0] DTE_RCV [CH_N] = '{CL_DATA, CL_DATA, CL_DATA,
    CL_RTS, CL_DTR, CL_DCD, CL_OFF, CL_LOW};
  localparam logic [2:0] DCE_DRV [CH_N] = '{CL_DATA, CL_DATA, CL_DATA,
    CL_RTS, CL_DTR, CL_DCD, CL_OFF, CL_LOW};
  localparam logic [2:0] DCE_RCV [CH_N] = '{CL_DATA, CL_DATA, CL_OFF,
    CL_RTS, CL_DTR, CL_OFF, CL_LOW, CL_LOW};

  // apb map and fields
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CAPT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DRV  = 8'h0c;
  localparam logic [7:0] OFF_RCV  = 8'h10;
  localparam int CTRL_DCE_BIT = 3;
  localparam int CTRL_SW_BIT  = 4;
  localparam int CAPT_GO_BIT  = 0;
  localparam logic [4:0] CTRL_RST = 5'h07;
  localparam logic [2:0] CODE_RST = SEL_PDN;

  typedef struct packed {
    logic [BIDIR_N-1:0] bidirDrive;
    smd_lvl_t [CH_N-1:0] drv;
    smd_lvl_t [CH_N-1:0] rcv;
  } smd_cfg_t;

endpackage

/* verilog/smd_mode_decoder.sv */
// serial line mode decoder with apb control
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module smd_mode_decoder
  import smd_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              ifaceSelBit0,
  input  wire logic              ifaceSelBit1,
  input  wire logic              ifaceSelBit2,
  input  wire logic              modeStrobe,
  input  wire logic              roleDcePin,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output smd_cfg_t               cfgOut
);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [4:0]  pinSync1_r;
  logic [4:0]  pinSync2_r;
  logic        strobeDly_r;
  logic        pinEdge;
  logic [4:0]  ctrl_r;
  logic [2:0]  capCode_r;
  logic        capDce_r;
  logic        swGo;
  logic        setupPh;
  logic        wrEn;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [31:0] rdMux;
  logic        mapped;
  smd_cfg_t    cfg_r;
  smd_lvl_t    drvNxt [CH_N];
  smd_lvl_t    rcvNxt [CH_N];

  // first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinSync1_r <= 5'h00;
      pinSync2_r <= 5'h00;
    end else begin
      pinSync1_r <= {roleDcePin, modeStrobe, ifaceSelBit2,
                     ifaceSelBit1, ifaceSelBit0};
      pinSync2_r <= pinSync1_r;
    end
  end

  // strobe history for edge detection
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strobeDly_r <= 1'b0;
    end else begin
      strobeDly_r <= pinSync2_r[3];
    end
  end

  // pins ignored while software owns the code
  assign pinEdge = pinSync2_r[3] & ~strobeDly_r & ~ctrl_r[CTRL_SW_BIT];

  // ----------------------------------------------------------
  // apb slave, one access cycle, no wait states
  // ----------------------------------------------------------
  assign setupPh = psel & ~penable;
  assign wrEn    = psel & penable & pready_r & pwrite;
  assign swGo    = wrEn & (paddr == OFF_CAPT) & pwdata[CAPT_GO_BIT];

  // decode of the mapped offsets
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: rdMux = {27'h0, ctrl_r};
      OFF_CAPT: rdMux = 32'h0000_0000;
      OFF_STAT: rdMux = {26'h0, ctrl_r[CTRL_SW_BIT],
                         capCode_r == SEL_PDN, capDce_r, capCode_r};
      OFF_DRV:  rdMux = {8'h00, cfg_r.drv};
      OFF_RCV:  rdMux = {8'h00, cfg_r.rcv};
      default:  mapped = 1'b0;
    endcase
  end

  // answer prepared in setup, shown in access
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setupPh;
      pslverr_r <= setupPh & ~mapped;
      if (setupPh & ~pwrite) begin
        prdata_r <= rdMux;
      end
    end
  end

  // software select code, role and ownership
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wrEn & (paddr == OFF_CTRL)) begin
      ctrl_r <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------
  // capture of the select code
  // ----------------------------------------------------------
  // held otherwise, so pin wander between edges is harmless
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      capCode_r <= CODE_RST;
      capDce_r  <= 1'b0;
    end else if (swGo) begin
      capCode_r <= ctrl_r[2:0];
      capDce_r  <= ctrl_r[CTRL_DCE_BIT];
    end else if (pinEdge) begin
      capCode_r <= pinSync2_r[2:0];
      capDce_r  <= pinSync2_r[4];
    end
  end

  // ----------------------------------------------------------
  // level decode
  // ----------------------------------------------------------
  // reserved code falls through to the 010 setting
  function automatic smd_lvl_t lvlOf(input logic [2:0] code,
                                     input logic [2:0] cls);
    smd_lvl_t l;
    l = LVL_OFF;
    if (cls != CL_OFF) begin
      case (code)
        SEL_V10:  l = LVL_V10;
        SEL_530A: l = (cls == CL_DTR || cls == CL_LOW) ?
                      LVL_V10 : LVL_V11;
        SEL_530,
        SEL_RSVD: l = (cls == CL_LOW) ? LVL_V10 : LVL_V11;
        SEL_X21:  l = (cls == CL_DCD || cls == CL_LOW) ?
                      LVL_OFF : LVL_V11;
        SEL_V35:  l = (cls == CL_DATA) ? LVL_V35 : LVL_V28;
        SEL_232:  l = LVL_V28;
        default:  l = LVL_OFF;
      endcase
    end
    return l;
  endfunction

  // only data class can reach V.35, low class never V.11
  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : gCh
      assign drvNxt[g] = lvlOf(capCode_r,
        capDce_r ? DCE_DRV[g] : DTE_DRV[g]);
      assign rcvNxt[g] = lvlOf(capCode_r,
        capDce_r ? DCE_RCV[g] : DTE_RCV[g]);
    end
  endgenerate

  // registered configuration, off means tri-stated
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_r <= '0;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        cfg_r.drv[i] <= drvNxt[i];
        cfg_r.rcv[i] <= rcvNxt[i];
      end
      cfg_r.bidirDrive[0] <= capDce_r;
      cfg_r.bidirDrive[1] <= capDce_r;
      cfg_r.bidirDrive[2] <= ~capDce_r;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign cfgOut  = cfg_r;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_CAPTURE: assert property (
    pinEdge & ~swGo |=> capCode_r == $past(pinSync2_r[2:0]))
    else $error("select code not captured on strobe");

  AST_HOLD: assert property (
    ~pinEdge & ~swGo |=> $stable(capCode_r) && $stable(capDce_r))
    else $error("select code moved without capture");

  AST_CODE0: assert property (
    capCode_r == SEL_V10 && !capDce_r
    |=> cfg_r.drv[0] == LVL_V10 && cfg_r.rcv[6] == LVL_OFF)
    else $error("code 000 levels wrong");

  AST_CODE1: assert property (
    capCode_r == SEL_530A
    |=> cfg_r.drv[4] == LVL_V10 && cfg_r.rcv[4] == LVL_V10
        && cfg_r.drv[0] == LVL_V11)
    else $error("code 001 levels wrong");

  AST_CODE2: assert property (
    capCode_r == SEL_530
    |=> cfg_r.drv[4] == LVL_V11 && cfg_r.rcv[7] == LVL_V10)
    else $error("code 010 levels wrong");

  AST_CODE3: assert property (
    capCode_r == SEL_X21
    |=> cfg_r.rcv[7] == LVL_OFF && cfg_r.drv[3] == LVL_V11)
    else $error("code 011 levels wrong");

  AST_CODE4: assert property (
    capCode_r == SEL_V35
    |=> cfg_r.rcv[0] == LVL_V35 && cfg_r.rcv[3] == LVL_V28)
    else $error("code 100 levels wrong");

  AST_CODE6: assert property (
    capCode_r == SEL_232
    |=> cfg_r.drv[0] == LVL_V28 && cfg_r.rcv[7] == LVL_V28)
    else $error("code 110 levels wrong");

  AST_PDOWN: assert property (
    capCode_r == SEL_PDN |=> cfg_r.drv == '0 && cfg_r.rcv == '0)
    else $error("power down left a channel on");

  AST_DTE_MAP: assert property (
    !capDce_r |=> cfg_r.drv[2] == LVL_OFF && cfg_r.drv[5] == LVL_OFF)
    else $error("unused dte driver active");

  AST_DCE_MAP: assert property (
    capDce_r |=> cfg_r.rcv[2] == LVL_OFF && cfg_r.rcv[5] == LVL_OFF)
    else $error("unused dce receiver active");

  AST_BIDIR3: assert property (
    ##1 cfg_r.bidirDrive[0] == $past(capDce_r))
    else $error("channel 3 direction wrong");

  AST_DCD_DIR: assert property (
    capDce_r && capCode_r != SEL_PDN && capCode_r != SEL_X21
    |=> cfg_r.bidirDrive[1] && cfg_r.drv[5] != LVL_OFF)
    else $error("dcd transceiver not driving");

  AST_GROUPS: assert property (
    cfg_r.drv[3] != LVL_V35 && cfg_r.rcv[7] != LVL_V11
    && cfg_r.rcv[7] != LVL_V35)
    else $error("level outside channel group");

  AST_LVL_RANGE: assert property (
    cfg_r.drv[1] <= LVL_V28 && cfg_r.rcv[1] <= LVL_V28)
    else $error("undefined level code");

  COV_PIN_V35: cover property (pinEdge ##1 capCode_r == SEL_V35);
  COV_SW_CAPT: cover property (swGo ##2 cfg_r.bidirDrive[0]);
  COV_PDN_EXIT: cover property (capCode_r == SEL_PDN ##1
                                capCode_r == SEL_232);

endmodule

`default_nettype wire

/* tb/smd_host_model.sv */
// host model driving the select pins and the capture strobe
`timescale 1ns/100ps
`default_nettype none

module smd_host_model (
  input  wire logic clk_sys,
  output logic      ifaceSelBit0,
  output logic      ifaceSelBit1,
  output logic      ifaceSelBit2,
  output logic      modeStrobe,
  output logic      roleDcePin
);
  // pins idle at the power-down code, strobe low
  initial begin
    {ifaceSelBit2, ifaceSelBit1, ifaceSelBit0} = 3'h7;
    modeStrobe = 1'b0;
    roleDcePin = 1'b0;
  end

  // move the pins with no strobe edge
  task automatic setPins(input logic [2:0] c, input logic dce);
    @(posedge clk_sys);
    {ifaceSelBit2, ifaceSelBit1, ifaceSelBit0} <= c;
    roleDcePin <= dce;
  endtask

  // pins held well around the edge: the sync flops add delay
  task automatic capture(input logic [2:0] c, input logic dce);
    setPins(c, dce);
    repeat (4) @(posedge clk_sys);
    modeStrobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    modeStrobe <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

`default_nettype wire

/* tb/smd_mode_decoder_bench.sv */
// self-checking bench for the mode decoder
`timescale 1ns/100ps
`default_nettype none

module smd_mode_decoder_bench
  import smd_pkg::*;
;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  wire logic   ifaceSelBit0, ifaceSelBit1, ifaceSelBit2;
  wire logic   modeStrobe, roleDcePin;
  smd_cfg_t    cfgOut;
  int          err_total, total_checks;
  // signal class per channel: 0 data 1 rts 2 dtr 3 dcd 4 test 5 unused
  int          chOut [8] = '{0, 0, 5, 1, 2, 5, 4, 4};
  int          chIn  [8] = '{0, 0, 0, 1, 2, 3, 5, 4};

  smd_host_model host (.clk_sys, .ifaceSelBit0, .ifaceSelBit1,
    .ifaceSelBit2, .modeStrobe, .roleDcePin);
  smd_mode_decoder dut (.clk_sys, .sys_rst, .ifaceSelBit0, .ifaceSelBit1,
    .ifaceSelBit2, .modeStrobe, .roleDcePin, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .cfgOut);

  // 250 MHz
  always #2 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // expected levels and checks
  // ---------------------------------------------------------------
  function automatic smd_lvl_t expLvl(input logic [2:0] c, input int k);
    if (k == 5 || c == 3'h7) return LVL_OFF;
    case (c)
      3'h0: return LVL_V10;
      3'h1: return (k == 2 || k == 4) ? LVL_V10 : LVL_V11;
      3'h3: return (k >= 3) ? LVL_OFF : LVL_V11;
      3'h4: return (k == 0) ? LVL_V35 : LVL_V28;
      3'h6: return LVL_V28;
      default: return (k == 4) ? LVL_V10 : LVL_V11;
    endcase
  endfunction

  function automatic smd_cfg_t expCfg(input logic [2:0] c, input logic d);
    smd_cfg_t e;
    e.bidirDrive = d ? 3'b011 : 3'b100;
    for (int i = 0; i < 8; i++) begin
      e.drv[i] = expLvl(c, d ? chIn[i] : chOut[i]);
      e.rcv[i] = expLvl(c, d ? chOut[i] : chIn[i]);
    end
    return e;
  endfunction

  task automatic chk32(input logic [31:0] g, x, input string m);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, x);
    end
  endtask

  task automatic chkCfg(input smd_cfg_t x);
    total_checks++;
    if (cfgOut !== x) begin
      err_total++;
      $display("[FAIL] %0t cfg got %h want %h", $time, cfgOut, x);
    end
  endtask

  // one transfer; pready looked at mid-cycle, where it has settled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk32(32'h0, 32'h1, "apb hang");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] x,
                       input logic xe);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    chk32(d, x, "read data");
    chk32({31'h0, er}, {31'h0, xe}, "error flag");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    smd_cfg_t e;
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chkCfg(expCfg(3'h7, 1'b0));
    rdChk(OFF_STAT, 32'h17, 1'b0);
    rdChk(OFF_CTRL, 32'h07, 1'b0);
    $display("test reset done");
    // every code in both roles, reserved code included
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) begin
        host.capture(3'(k), 1'(r));
        e = expCfg(3'(k), 1'(r));
        chkCfg(e);
        rdChk(OFF_DRV, {8'h0, e.drv}, 1'b0);
        rdChk(OFF_RCV, {8'h0, e.rcv}, 1'b0);
        rdChk(OFF_STAT, {26'h0, 1'b0, k == 7, r[0], k[2:0]}, 1'b0);
      end
    end
    $display("test pin codes done");
    host.setPins(3'h0, 1'b0);
    repeat (12) @(posedge clk_sys);
    chkCfg(e);
    $display("test hold done");
    wr(OFF_CTRL, 32'h1c);
    wr(OFF_CAPT, 32'h1);
    repeat (4) @(posedge clk_sys);
    chkCfg(expCfg(3'h4, 1'b1));
    // software owns the code, so a pin strobe must not disturb it
    host.capture(3'h6, 1'b0);
    chkCfg(expCfg(3'h4, 1'b1));
    rdChk(OFF_STAT, 32'h2c, 1'b0);
    rdChk(OFF_CAPT, 32'h0, 1'b0);
    rdChk(8'h20, 32'h0, 1'b1);
    $display("test software capture done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chkCfg(expCfg(3'h7, 1'b0));
    rdChk(OFF_CTRL, 32'h07, 1'b0);
    $display("test second reset done");
    test_done;
  end

  // whole run is some 460 cycles; allow ample margin
  initial begin
    #60000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end
endmodule

`default_nettype wire
